/* File: shared/del_pkg.sv */
package del_pkg;
  // log geometry
  localparam int unsigned LOG_DEPTH = 9;
  localparam int unsigned PTR_W     = 4;
  // fixed prefix in front of class and number
  localparam logic [15:0] ID_PREFIX = 16'hf1c8;
  // backplane event class and numbers
  localparam logic [7:0] CLS_BPLANE   = 8'h1e;
  localparam logic [7:0] NUM_ABORT    = 8'h0d;
  localparam logic [7:0] NUM_RD_FAIL  = 8'h0e;
  localparam logic [7:0] NUM_WR_FAIL  = 8'h0f;
  localparam logic [7:0] NUM_BAD_SIZE = 8'h41;
  // protocol master exception class and nak number
  localparam logic [7:0] CLS_PROTO    = 8'h0e;
  localparam logic [7:0] NUM_EXC_NAK  = 8'h67;
  localparam logic [7:0] EXC_CODE_NAK = 8'h07;
  // length range accepted from the host
  localparam logic [10:0] XFER_MIN = 11'h001;
  localparam logic [10:0] XFER_MAX = 11'h400;
  // diagnostic records, byte 0 in low byte
  localparam logic [31:0] DIAG_WIRE_BREAK = 32'h00020c25;
  localparam logic [31:0] DIAG_PARAM_ERR  = 32'h00000c83;
  // interrupt disabled after default parameterisation
  localparam logic        IRQ_EN_RESET    = 1'b0;
  // source selector for generic events
  typedef enum logic [1:0] {
    DEL_SRC_HW,
    DEL_SRC_PARAM,
    DEL_SRC_REQ,
    DEL_SRC_XFER
  } del_src_t;
endpackage : del_pkg

/* File: shared/del_log_if.sv */
`timescale 1ns/1ps
// one event write towards the ring store
interface del_log_if;
  logic       wr;   // one-cycle write strobe
  logic [7:0] cls;  // event class
  logic [7:0] num;  // event number
  logic       clr;  // wipe all entries
  modport src  (output wr, output cls, output num, output clr);
  modport sink (input wr, input cls, input num, input clr);
endinterface : del_log_if

/* File: rtl/del_ring.sv */
`timescale 1ns/1ps
// ring of event entries, read back newest first
module del_ring (
  input  wire logic                        ref_clk,
  input  wire logic                        nrst,
  del_log_if.sink                          lg,
  input  wire logic [del_pkg::PTR_W-1:0]   rd_idx,
  output logic      [7:0]                  rd_cls,
  output logic      [7:0]                  rd_num,
  output logic      [del_pkg::PTR_W-1:0]   count
);
  // state in one packed struct
  typedef struct packed {
    logic [del_pkg::PTR_W-1:0] head;   // next slot to write
    logic [del_pkg::PTR_W-1:0] cnt;    // entries held
    logic [7:0]                rcls;
    logic [7:0]                rnum;
  } del_ring_st_t;

  del_ring_st_t st;
  del_ring_st_t next_st;
  logic [15:0]  mem [del_pkg::LOG_DEPTH];  // class and number per entry

  // wrap a pointer step backwards
  function automatic logic [del_pkg::PTR_W-1:0] del_back(input logic [del_pkg::PTR_W-1:0] p,
                                                         input logic [del_pkg::PTR_W-1:0] n);
    logic [del_pkg::PTR_W:0] t;
    t = {1'b0, p} + 5'(del_pkg::LOG_DEPTH) - {1'b0, n};
    if (t >= 5'(del_pkg::LOG_DEPTH)) t = t - 5'(del_pkg::LOG_DEPTH);
    return t[del_pkg::PTR_W-1:0];
  endfunction : del_back

  // pointer and readout update
  always_comb begin
    logic [del_pkg::PTR_W-1:0] slot;
    slot    = del_back(st.head, rd_idx + 4'h1);
    next_st = st;
    // newest entry sits just behind head
    next_st.rcls = (rd_idx < st.cnt) ? mem[slot][15:8] : 8'h00;
    next_st.rnum = (rd_idx < st.cnt) ? mem[slot][7:0]  : 8'h00;
    if (lg.clr) begin
      next_st.head = '0;
      next_st.cnt  = '0;
    end else if (lg.wr) begin
      next_st.head = (st.head == 4'(del_pkg::LOG_DEPTH - 1)) ? 4'h0 : st.head + 4'h1;
      // when full the oldest slot is simply overwritten
      if (st.cnt != 4'(del_pkg::LOG_DEPTH)) next_st.cnt = st.cnt + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) st <= '0;
    else       st <= next_st;
  end

  // storage has no reset; cnt hides stale slots
  always_ff @(posedge ref_clk) begin
    if (lg.wr && !lg.clr) mem[st.head] <= {lg.cls, lg.num};
  end

  assign rd_cls = st.rcls;
  assign rd_num = st.rnum;
  assign count  = st.cnt;

  // count never passes depth
  cnt_bound_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st.cnt <= 4'(del_pkg::LOG_DEPTH)) else $error("log count above depth");
  // full log stays full on write
  full_stays_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st.cnt == 4'(del_pkg::LOG_DEPTH) && lg.wr && !lg.clr) |=> st.cnt == 4'(del_pkg::LOG_DEPTH))
    else $error("full log lost entries on write");
  // clear empties the log
  clear_empty_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    lg.clr |=> st.cnt == 4'h0) else $error("clear did not empty log");
  // newest is read at index zero
  newest_first_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (lg.wr && !lg.clr && rd_idx == 4'h0) ##1 (rd_idx == 4'h0 && !lg.clr)
      |=> rd_cls == $past(lg.cls, 2)) else $error("newest entry not first");
endmodule : del_ring

/* File: rtl/del_top.sv */
`timescale 1ns/1ps
// Behaviour
// - ring log holds at most nine entries
// - full log drops oldest on new entry
// - readout returns newest entry first
// - power loss or new parameters clear log
// - event id is f1c8, class, number
// - parameter enables interrupt, default off
// - interrupt only for wire break, param error
// - four-byte info record with each interrupt
// - wire break record 25 0c 02 00
// - param error record 83 0c 00 00
// - aborted request logs 1e 0d
// - read/write fails log 1e 0e/0f, keep return
// - length outside 1..1024 rejected, logs 1e 41
// - master nak exception 07 logs 0e 67
// - log accepts all four fault groups
module del_top (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // parameterisation
  input  wire logic        param_load,       // new parameter set applied
  input  wire logic        param_irq_en,     // diag interrupt enable in that set
  input  wire logic        param_err,        // parameterisation fault pulse
  input  wire logic        rxd_wire_break,   // receive line broken pulse
  // backplane request side
  input  wire logic        req_abort,        // request lost to restart/reset
  input  wire logic        rd_rec_fail,      // read-record transfer failed
  input  wire logic        wr_rec_fail,      // write-record transfer failed
  input  wire logic [15:0] xfer_ret,         // transfer return value
  input  wire logic        size_check,       // new request length to check
  input  wire logic [10:0] transfer_length,  // requested byte count
  output logic             size_ok,          // length accepted
  // protocol master reply
  input  wire logic        exc_valid,        // exception reply pulse
  input  wire logic [7:0]  exc_code,         // exception code
  // generic fault sources
  input  wire logic        gen_valid,
  input  wire del_pkg::del_src_t gen_src,
  input  wire logic [7:0]  gen_cls,
  input  wire logic [7:0]  gen_num,
  // host readout
  input  wire logic [3:0]  rd_idx,           // 0 is newest
  output logic      [31:0] rd_event_id,      // prefix, class, number
  output logic      [3:0]  log_count,
  output logic      [15:0] xfer_ret_saved,
  // diagnostic interrupt
  output logic             diag_irq,         // one-cycle pulse
  output logic      [31:0] diag_info,        // byte 0 in low byte
  input  wire logic        power_fail        // loss of supply
);
  // all state in one packed struct
  typedef struct packed {
    logic        irq_en;
    logic        irq;
    logic [31:0] info;
    logic [15:0] ret;
    logic        ok;
  } del_top_st_t;

  del_top_st_t st;
  del_top_st_t next_st;
  del_log_if   lg ();
  logic [7:0]  rcls;
  logic [7:0]  rnum;

  // build id from class and number
  function automatic logic [31:0] del_id(input logic [7:0] c, input logic [7:0] n);
    return {del_pkg::ID_PREFIX, c, n};
  endfunction : del_id

  // pick one event per cycle, most serious first
  always_comb begin
    lg.wr  = 1'b1;
    lg.cls = del_pkg::CLS_BPLANE;
    lg.num = del_pkg::NUM_ABORT;
    lg.clr = param_load | power_fail;
    if (req_abort) begin
      lg.num = del_pkg::NUM_ABORT;
    end else if (rd_rec_fail) begin
      lg.num = del_pkg::NUM_RD_FAIL;
    end else if (wr_rec_fail) begin
      lg.num = del_pkg::NUM_WR_FAIL;
    end else if (size_check && (transfer_length < del_pkg::XFER_MIN || transfer_length > del_pkg::XFER_MAX)) begin
      lg.num = del_pkg::NUM_BAD_SIZE;
    end else if (exc_valid && exc_code == del_pkg::EXC_CODE_NAK) begin
      lg.cls = del_pkg::CLS_PROTO;
      lg.num = del_pkg::NUM_EXC_NAK;
    end else if (gen_valid) begin
      // every fault group goes in unchanged
      lg.cls = gen_cls;
      lg.num = gen_num;
    end else begin
      lg.wr = 1'b0;
    end
  end

  // interrupt, record and length verdict
  always_comb begin
    next_st     = st;
    next_st.irq = 1'b0;
    if (param_load) next_st.irq_en = param_irq_en;
    if (rd_rec_fail || wr_rec_fail) next_st.ret = xfer_ret;
    if (size_check) next_st.ok = transfer_length >= del_pkg::XFER_MIN && transfer_length <= del_pkg::XFER_MAX;
    // enable is read before this cycle's load takes hold
    if (st.irq_en && rxd_wire_break) begin
      next_st.irq  = 1'b1;
      next_st.info = del_pkg::DIAG_WIRE_BREAK;
    end else if (st.irq_en && param_err) begin
      next_st.irq  = 1'b1;
      next_st.info = del_pkg::DIAG_PARAM_ERR;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st        <= '0;
      st.irq_en <= del_pkg::IRQ_EN_RESET;
    end else begin
      st <= next_st;
    end
  end

  del_ring u_ring (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .lg      (lg),
    .rd_idx  (rd_idx),
    .rd_cls  (rcls),
    .rd_num  (rnum),
    .count   (log_count)
  );

  assign rd_event_id    = del_id(rcls, rnum);
  assign diag_irq       = st.irq;
  assign diag_info      = st.info;
  assign xfer_ret_saved = st.ret;
  assign size_ok        = st.ok;

  // record matches the event that raised it
  irq_record_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st.irq_en && rxd_wire_break && !param_load) |=> diag_irq && diag_info == 32'h00020c25)
    else $error("wire break record wrong");
  param_record_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st.irq_en && param_err && !rxd_wire_break) |=> diag_irq && diag_info == 32'h00000c83)
    else $error("param error record wrong");
  // no interrupt when disabled or without cause
  irq_gated_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!st.irq_en || !(rxd_wire_break || param_err)) |=> !diag_irq)
    else $error("interrupt without enabled cause");
  // enable follows the loaded parameter
  irq_enable_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    param_load |=> st.irq_en == $past(param_irq_en)) else $error("enable not loaded");
  // zero length is not accepted
  bad_size_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (size_check && transfer_length == 11'h000) |=> !size_ok) else $error("zero length accepted");
  abort_log_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    req_abort |-> lg.wr && lg.cls == 8'h1e && lg.num == 8'h0d) else $error("abort not logged");
  id_prefix_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    rd_event_id[31:16] == 16'hf1c8) else $error("id prefix wrong");
  nak_log_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (exc_valid && exc_code == 8'h07 && !req_abort && !rd_rec_fail && !wr_rec_fail && !size_check)
      |-> lg.wr && lg.num == 8'h67) else $error("nak not logged");
endmodule : del_top

/* File: tb/del_host.sv */
`timescale 1ns/1ps
// host cpu model: picks each diag record off the backplane
module del_host (
  input  wire logic        ref_clk,
  input  wire logic        diag_irq,
  input  wire logic [31:0] diag_info,
  output int               irq_cnt,
  output logic      [31:0] info_seen
);
  // record is only promised in the pulse cycle, so latch it there
  int          cnt  = 0;      // interrupts seen so far
  logic [31:0] seen = 32'h0;  // last record picked up
  // count every interrupt, wanted or not; mid-cycle, where the pulse has settled
  always @(negedge ref_clk) begin
    if (diag_irq === 1'b1) begin
      cnt  <= cnt + 1;
      seen <= diag_info;
    end
  end
  assign irq_cnt   = cnt;
  assign info_seen = seen;
endmodule : del_host

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  logic ref_clk = 0, nrst = 0, param_load = 0, param_irq_en = 0, param_err = 0, rxd_wire_break = 0;
  logic req_abort = 0, rd_rec_fail = 0, wr_rec_fail = 0, size_check = 0, exc_valid = 0, gen_valid = 0;
  logic [15:0] xfer_ret = 16'h0;
  logic [10:0] transfer_length = 11'h0;
  logic [7:0]  exc_code = 8'h0, gen_cls = 8'h0, gen_num = 8'h0;
  logic [3:0]  rd_idx = 4'h0;
  logic        power_fail = 0;
  del_pkg::del_src_t gen_src = del_pkg::DEL_SRC_HW;
  logic size_ok, diag_irq;
  logic [31:0] rd_event_id, diag_info, info_seen;
  logic [3:0]  log_count;
  logic [15:0] xfer_ret_saved;
  int failures = 0, n_tests = 0, cyc = 0, irq_cnt;
  logic [31:0] exp_q[$];   // expected diag records in order
  logic [15:0] hist[$];    // model of log, newest first
  del_top uut (.ref_clk(ref_clk), .nrst(nrst), .param_load(param_load), .param_irq_en(param_irq_en),
    .param_err(param_err), .rxd_wire_break(rxd_wire_break), .req_abort(req_abort),
    .rd_rec_fail(rd_rec_fail), .wr_rec_fail(wr_rec_fail), .xfer_ret(xfer_ret), .size_check(size_check),
    .transfer_length(transfer_length), .size_ok(size_ok), .exc_valid(exc_valid), .exc_code(exc_code),
    .gen_valid(gen_valid), .gen_src(gen_src), .gen_cls(gen_cls), .gen_num(gen_num), .rd_idx(rd_idx),
    .rd_event_id(rd_event_id), .log_count(log_count), .xfer_ret_saved(xfer_ret_saved),
    .diag_irq(diag_irq), .diag_info(diag_info), .power_fail(power_fail));
  del_host host (.ref_clk(ref_clk), .diag_irq(diag_irq), .diag_info(diag_info),
    .irq_cnt(irq_cnt), .info_seen(info_seen));
  // 25 mhz clock
  always #20 ref_clk = ~ref_clk;
  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // verdict and end of run
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // hang guard, run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  // scoreboard side: each interrupt takes the oldest expected record, sampled mid-cycle
  always @(negedge ref_clk) begin
    if (diag_irq === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected irq", diag_info, 32'h0);
      else chk("diag_info", diag_info, exp_q.pop_front());
    end
  end
  // note one expected log entry; ring keeps nine, oldest falls off
  task automatic lg(input logic [7:0] c, input logic [7:0] n);
    hist.push_front({c, n});
    if (hist.size() > 9) void'(hist.pop_back());
  endtask : lg
  // one-cycle request pulse, then one idle cycle
  task automatic ev(input int k, input logic [15:0] v);
    case (k)
      0: req_abort = 1;
      1: begin rd_rec_fail = 1; xfer_ret = v; end
      2: begin wr_rec_fail = 1; xfer_ret = v; end
      3: begin size_check = 1; transfer_length = v[10:0]; end
      4: begin exc_valid = 1; exc_code = v[7:0]; end
      5: begin gen_valid = 1; gen_cls = v[15:8]; gen_num = v[7:0]; gen_src = del_pkg::del_src_t'(v[1:0]); end
      6: rxd_wire_break = 1;
      7: param_err = 1;
      8: begin param_load = 1; param_irq_en = v[0]; end
      default: power_fail = 1;
    endcase
    @(negedge ref_clk);
    {req_abort, rd_rec_fail, wr_rec_fail, size_check, exc_valid, gen_valid} = 6'h0;
    {rxd_wire_break, param_err, param_load, power_fail} = 4'h0;
    @(negedge ref_clk);
  endtask : ev
  initial begin
    void'($urandom(47831));
    repeat (10) @(negedge ref_clk);
    nrst = 1;
    chk("log_count", {28'h0, log_count}, 32'h0);
    // interrupt: off by default, on after load, only two causes
    ev(6, 16'h0);
    ev(8, 16'h1);
    exp_q.push_back(32'h00020c25);
    ev(6, 16'h0);
    exp_q.push_back(32'h00000c83);
    ev(7, 16'h0);
    ev(0, 16'h0);
    repeat (3) @(negedge ref_clk);
    chk("irq_cnt", irq_cnt, 32'h2);
    chk("info_seen", info_seen, 32'h00000c83);
    $display("test irq done");
    // reparameterise: log wiped
    ev(8, 16'h0);
    chk("log_count", {28'h0, log_count}, 32'h0);
    // backplane events and length limits
    ev(0, 16'h0); lg(8'h1e, 8'h0d);
    ev(1, 16'h1234); lg(8'h1e, 8'h0e);
    ev(2, 16'hbeef); lg(8'h1e, 8'h0f);
    chk("xfer_ret_saved", {16'h0, xfer_ret_saved}, 32'hbeef);
    ev(3, 16'h0); lg(8'h1e, 8'h41);
    chk("size_ok", {31'h0, size_ok}, 32'h0);
    ev(3, 16'h1);
    chk("size_ok", {31'h0, size_ok}, 32'h1);
    ev(3, 16'h400);
    chk("size_ok", {31'h0, size_ok}, 32'h1);
    ev(3, 16'h401); lg(8'h1e, 8'h41);
    chk("size_ok", {31'h0, size_ok}, 32'h0);
    // other exception codes stay out of the log
    ev(4, 16'h6);
    ev(4, 16'h7); lg(8'h0e, 8'h67);
    // random generic faults push the ring past full
    for (int i = 0; i < 6; i++) begin
      logic [15:0] r;
      r = 16'($urandom);
      ev(5, r); lg(r[15:8], r[7:0]);
    end
    chk("log_count", {28'h0, log_count}, 32'h9);
    // readout newest first, one past the end reads the bare prefix
    for (int i = 0; i < 10; i++) begin
      rd_idx = 4'(i);
      repeat (2) @(negedge ref_clk);
      chk("rd_event_id", rd_event_id, (i < 9) ? {16'hf1c8, hist[i]} : 32'hf1c80000);
    end
    $display("test log done");
    ev(9, 16'h0);
    chk("log_count", {28'h0, log_count}, 32'h0);
    chk("irq_cnt", irq_cnt, 32'h2);
    // every expected record must have been taken by an interrupt
    chk("pending_irq", exp_q.size(), 32'h0);
    $display("test clear done");
    report_and_stop();
  end
endmodule : tb
